// File: common/dts_pkg.sv
// Purpose: constants for the debug trigger and status block
// Assumes: axi4-lite register bus, 32-bit data, one word per register
// Notes:   register offsets are chosen locally
package dts_pkg;
   localparam logic [7:0] OFF_CONTROL = 8'h00;
   localparam logic [7:0] OFF_TRIGGER = 8'h04;
   localparam logic [7:0] OFF_STATUS  = 8'h08;
   localparam logic [7:0] OFF_IRQ_STS = 8'h0c;
   localparam logic [7:0] OFF_IRQ_MSK = 8'h10;
   // control register fields
   localparam int CTL_ENABLE_BIT = 7;
   localparam int CTL_RUN_BIT    = 6;
   localparam logic [7:0] CTL_WMASK = 8'hc0;
   // trigger configuration fields
   localparam int TRG_TYPE_BIT  = 7;
   localparam int TRG_BEGIN_BIT = 6;
   localparam logic [7:0] TRG_WMASK = 8'hcf;
   localparam logic [7:0] TRG_RESET = 8'h00;
   // status fields
   localparam int STS_A_BIT   = 7;
   localparam int STS_B_BIT   = 6;
   localparam int STS_RUN_BIT = 5;
   // interrupt status fields
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_A_BIT    = 1;
   localparam int IRQ_B_BIT    = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;
   localparam logic [3:0] CNT_MAX = 4'h8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [3:0] {
      DTS_A_ONLY      = 4'b0000,
      DTS_A_OR_B      = 4'b0001,
      DTS_A_THEN_B    = 4'b0010,
      DTS_EV_B        = 4'b0011,
      DTS_A_THEN_EV_B = 4'b0100,
      DTS_A_AND_B     = 4'b0101,
      DTS_A_NOT_B     = 4'b0110,
      DTS_INSIDE      = 4'b0111,
      DTS_OUTSIDE     = 4'b1000
   } dts_mode_e;
endpackage

// File: design/dts_top.sv
// Purpose: trigger configuration and run status of a bus-capture debug unit
// Assumes: comparator, opcode tracking and fifo fill inputs are synchronous
// Notes:   registers reached over axi4-lite
`timescale 1ns/1ps
module dts_top (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        secure_state,
   input  wire logic        cmp_a_match,
   input  wire logic        cmp_b_match,
   input  wire logic        cmp_a_exec,
   input  wire logic        cmp_b_exec,
   input  wire logic        addr_ge_a,
   input  wire logic        addr_le_b,
   input  wire logic        addr_valid,
   input  wire logic        fifo_word_stored,
   input  wire logic        fifo_full,
   output logic             trigger_q,
   output logic             capture_enable_q,
   output logic             begin_trace_q,
   output logic             event_only_q,
   output logic             high_byte_zero_q,
   output logic             run_start_q,
   output logic             irq_q
);

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [7:0] ctl_q;
   logic [7:0] trg_q;
   logic       flag_a_q;
   logic       flag_b_q;
   logic [3:0] cnt_q;
   logic       a_seen_q;
   logic [2:0] irq_sts_q;
   logic [2:0] irq_msk_q;
   logic       aw_hold_q;
   logic       w_hold_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;

   logic       armed;
   logic [3:0] mode;
   logic       ev_only;
   logic       begin_tr;
   logic       hit_a;
   logic       hit_b;
   logic       trig;
   logic       run_done;
   logic       wr_go;
   logic       rd_go;
   logic [7:0] wbyte;
   logic       ctl_wr;
   logic       start;
   logic       stop_manual;
   logic       trg_wr;
   logic [2:0] irq_clr;

   function automatic logic is_event_only(input logic [3:0] m);
      return (m == dts_pkg::DTS_EV_B) || (m == dts_pkg::DTS_A_THEN_EV_B);
   endfunction

   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                        input logic [7:0] msk);
      return (old & ~msk) | (nw & msk);
   endfunction

   function automatic logic [7:0] s_axi_wstrb_sel(input logic [31:0] d, input logic [3:0] s);
      return s[0] ? d[7:0] : 8'h00;
   endfunction

   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   function automatic logic [7:0] status_byte(input logic fa, input logic fb, input logic arm,
                                               input logic [3:0] c);
      return {fa, fb, arm, 1'b0, c};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // trigger decode
   assign armed    = ctl_q[dts_pkg::CTL_ENABLE_BIT] & ctl_q[dts_pkg::CTL_RUN_BIT];
   assign mode     = trg_q[3:0];
   assign ev_only  = is_event_only(mode);
   assign begin_tr = ev_only | trg_q[dts_pkg::TRG_BEGIN_BIT];
   assign hit_a    = trg_q[dts_pkg::TRG_TYPE_BIT] ? cmp_a_exec : cmp_a_match;
   assign hit_b    = trg_q[dts_pkg::TRG_TYPE_BIT] ? cmp_b_exec : cmp_b_match;

   always_comb begin
      case (mode)
         dts_pkg::DTS_A_ONLY:      trig = hit_a;
         dts_pkg::DTS_A_OR_B:      trig = hit_a | hit_b;
         dts_pkg::DTS_A_THEN_B:    trig = a_seen_q & hit_b;
         dts_pkg::DTS_EV_B:        trig = hit_b;
         dts_pkg::DTS_A_THEN_EV_B: trig = a_seen_q & hit_b;
         dts_pkg::DTS_A_AND_B:     trig = hit_a & hit_b;
         dts_pkg::DTS_A_NOT_B:     trig = hit_a & ~hit_b;
         dts_pkg::DTS_INSIDE:      trig = addr_valid & addr_ge_a & addr_le_b;
         dts_pkg::DTS_OUTSIDE:     trig = addr_valid & ~(addr_ge_a & addr_le_b);
         default:                  trig = 1'b0;
      endcase
   end

   assign run_done = armed & (begin_tr ? fifo_full : trig);

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite handshake
   assign wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
   assign rd_go = s_axi_arvalid & s_axi_arready;
   assign wbyte = s_axi_wstrb_sel(w_data_q, w_strb_q);
   assign ctl_wr = wr_go & addr_is(aw_addr_q, dts_pkg::OFF_CONTROL) & w_strb_q[0];
   assign start = ctl_wr & ~armed & wbyte[dts_pkg::CTL_RUN_BIT]
                  & (wbyte[dts_pkg::CTL_ENABLE_BIT] & ~secure_state);
   assign stop_manual = ctl_wr & armed
                        & ~(wbyte[dts_pkg::CTL_RUN_BIT] & wbyte[dts_pkg::CTL_ENABLE_BIT]);
   assign trg_wr = wr_go & addr_is(aw_addr_q, dts_pkg::OFF_TRIGGER) & w_strb_q[0]
                   & ~ctl_q[dts_pkg::CTL_RUN_BIT];
   assign irq_clr = (wr_go & addr_is(aw_addr_q, dts_pkg::OFF_IRQ_STS)) ? wbyte[2:0] : 3'h0;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         aw_hold_q     <= 1'b0;
         aw_addr_q     <= 8'h00;
      end else begin
         s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
         end else if (wr_go) begin
            aw_hold_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_axi_wready <= 1'b0;
         w_hold_q     <= 1'b0;
         w_data_q     <= 32'h0000_0000;
         w_strb_q     <= 4'h0;
      end else begin
         s_axi_wready <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_wvalid & s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_hold_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= dts_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (aw_addr_q > dts_pkg::OFF_IRQ_MSK) ? dts_pkg::RESP_SLVERR
                                                           : dts_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= dts_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= dts_pkg::RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
               dts_pkg::OFF_CONTROL: s_axi_rdata <= {24'h000000, ctl_q};
               dts_pkg::OFF_TRIGGER: s_axi_rdata <= {24'h000000, trg_q};
               dts_pkg::OFF_STATUS:  begin
                  s_axi_rdata <= {24'h000000, status_byte(flag_a_q, flag_b_q, armed,
                                                          cnt_q)};
               end
               dts_pkg::OFF_IRQ_STS: s_axi_rdata <= {29'h00000000, irq_sts_q};
               dts_pkg::OFF_IRQ_MSK: s_axi_rdata <= {29'h00000000, irq_msk_q};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= dts_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctl_q <= 8'h00;
      end else if (ctl_wr) begin
         ctl_q <= merge(ctl_q, wbyte, dts_pkg::CTL_WMASK);
         if (secure_state) begin
            ctl_q[dts_pkg::CTL_ENABLE_BIT] <= 1'b0;
         end
      end else if (run_done) begin
         ctl_q[dts_pkg::CTL_RUN_BIT] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // trigger configuration
   always_ff @(posedge core_clk) begin
      if (rst) begin
         trg_q <= dts_pkg::TRG_RESET;
      end else if (trg_wr) begin
         trg_q <= merge(trg_q, wbyte, dts_pkg::TRG_WMASK);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status flags and count (no bus write path)
   always_ff @(posedge core_clk) begin
      if (rst) begin
         flag_a_q <= 1'b0;
         flag_b_q <= 1'b0;
         a_seen_q <= 1'b0;
      end else if (start) begin
         flag_a_q <= 1'b0;
         flag_b_q <= 1'b0;
         a_seen_q <= 1'b0;
      end else if (armed) begin
         if (hit_a) begin
            flag_a_q <= 1'b1;
            a_seen_q <= 1'b1;
         end
         if (hit_b) begin
            flag_b_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_q <= 4'h0;
      end else if (start) begin
         cnt_q <= 4'h0;
      end else if (armed && fifo_word_stored && cnt_q != dts_pkg::CNT_MAX) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: done, match a, match b; write one to clear, set wins
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_sts_q <= dts_pkg::IRQ_RESET;
         irq_msk_q <= dts_pkg::IRQ_RESET;
      end else begin
         irq_sts_q <= (irq_sts_q & ~irq_clr)
                      | {armed & hit_b, armed & hit_a, run_done};
         if (wr_go && addr_is(aw_addr_q, dts_pkg::OFF_IRQ_MSK)) begin
            irq_msk_q <= wbyte[2:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs toward the fifo, comparators and interrupt line
   always_ff @(posedge core_clk) begin
      if (rst) begin
         trigger_q        <= 1'b0;
         capture_enable_q <= 1'b0;
         begin_trace_q    <= 1'b0;
         event_only_q     <= 1'b0;
         high_byte_zero_q <= 1'b0;
         run_start_q      <= 1'b0;
         irq_q            <= 1'b0;
      end else begin
         trigger_q        <= armed & trig;
         capture_enable_q <= armed & ~run_done & ~stop_manual;
         begin_trace_q    <= begin_tr;
         event_only_q     <= ev_only;
         high_byte_zero_q <= ev_only;
         run_start_q      <= start;
         irq_q            <= |(irq_sts_q & irq_msk_q);
      end
   end

endmodule // dts_top

// File: test/dts_properties.sv
// Purpose: port-level checks of the debug trigger and status block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to dts_top below
`timescale 1ns/1ps
module dts_properties (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic secure_state,
   input wire logic fifo_full,
   input wire logic trigger_q,
   input wire logic capture_enable_q,
   input wire logic begin_trace_q,
   input wire logic event_only_q,
   input wire logic high_byte_zero_q,
   input wire logic run_start_q,
   input wire logic irq_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   sequence s_full_end;
      capture_enable_q && begin_trace_q && fifo_full;
   endsequence
   sequence s_trig_end;
      trigger_q && !begin_trace_q;
   endsequence
   ////////////////////////////////////////
   a_trig_when_armed: assert property (trigger_q |-> $past(capture_enable_q))
      else $error("trigger while not armed");
   a_secure_blocks_arm: assert property ($rose(capture_enable_q) |-> !$past(secure_state, 2))
      else $error("armed while secure");
   a_full_ends_run: assert property (s_full_end |=> !capture_enable_q)
      else $error("begin trace not ended on full");
   a_trig_ends_run: assert property (s_trig_end |-> ##[0:1] !capture_enable_q)
      else $error("end trace not ended on trigger");
   a_event_is_begin: assert property (event_only_q |-> begin_trace_q)
      else $error("event-only mode not begin trace");
   a_high_byte_zero: assert property (high_byte_zero_q == event_only_q)
      else $error("high byte zero flag wrong");
   a_start_one_pulse: assert property (run_start_q |=> !run_start_q)
      else $error("run start pulse too long");
   a_reset_idle: assert property ($fell(rst) |-> !capture_enable_q && !irq_q)
      else $error("not idle after reset");
endmodule // dts_properties

bind dts_top dts_properties i_dts_properties (
   .core_clk(core_clk), .rst(rst), .secure_state(secure_state), .fifo_full(fifo_full),
   .trigger_q(trigger_q), .capture_enable_q(capture_enable_q), .begin_trace_q(begin_trace_q),
   .event_only_q(event_only_q), .high_byte_zero_q(high_byte_zero_q),
   .run_start_q(run_start_q), .irq_q(irq_q)
);

// File: test/dts_fifo_model.sv
// Purpose: capture fifo fill side facing the trigger block
// Assumes: one word every other cycle while filling and armed
// Notes:   eight words make the fifo full; cleared at run start
`timescale 1ns/1ps
module dts_fifo_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic run_start_q,
   input wire logic capture_enable_q,
   input wire logic fill,
   output logic     fifo_word_stored,
   output logic     fifo_full
);
   logic [3:0] words_q;
   always_ff @(posedge core_clk) begin
      if (rst || run_start_q) begin
         words_q          <= 4'h0;
         fifo_word_stored <= 1'b0;
      end else begin
         fifo_word_stored <= fill && capture_enable_q && words_q < 4'h8 && !fifo_word_stored;
         if (fifo_word_stored) words_q <= words_q + 4'h1;
      end
   end
   assign fifo_full = (words_q == 4'h8);
endmodule // dts_fifo_model

// File: test/dts_top_tb.sv
// Purpose: self-checking bench of the debug trigger and status block
// Assumes: axi4-lite master tasks, fifo fill model on the far side
// Notes:   one task per scenario
`timescale 1ns/1ps
module dts_top_tb;
   logic        core_clk, rst, secure_state, fill, fifo_word_stored, fifo_full;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, lresp;
   logic        cmp_a_match, cmp_b_match, cmp_a_exec, cmp_b_exec;
   logic        addr_ge_a, addr_le_b, addr_valid;
   logic        trigger_q, capture_enable_q, begin_trace_q, event_only_q, high_byte_zero_q;
   logic        run_start_q, irq_q;
   int          n_fail, checked;
   dts_top i_dts_top (
      .core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .secure_state(secure_state),
      .cmp_a_match(cmp_a_match), .cmp_b_match(cmp_b_match), .cmp_a_exec(cmp_a_exec),
      .cmp_b_exec(cmp_b_exec), .addr_ge_a(addr_ge_a), .addr_le_b(addr_le_b),
      .addr_valid(addr_valid), .fifo_word_stored(fifo_word_stored), .fifo_full(fifo_full),
      .trigger_q(trigger_q), .capture_enable_q(capture_enable_q),
      .begin_trace_q(begin_trace_q), .event_only_q(event_only_q),
      .high_byte_zero_q(high_byte_zero_q), .run_start_q(run_start_q), .irq_q(irq_q)
   );
   dts_fifo_model i_dts_fifo_model (
      .core_clk(core_clk), .rst(rst), .run_start_q(run_start_q),
      .capture_enable_q(capture_enable_q), .fill(fill),
      .fifo_word_stored(fifo_word_stored), .fifo_full(fifo_full)
   );
   ////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata[7:0];
      lresp = s_axi_rresp;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(d, e);
   endtask
   task automatic irqc(input logic [7:0] a, input logic [7:0] d, input logic e);
      wr(a, d);
      repeat (2) @(posedge core_clk);
      chk({7'h0, irq_q}, {7'h0, e});
   endtask
   task automatic run(input logic [7:0] cfg, input logic [4:0] ev, input logic e);
      logic hit;
      wr(dts_pkg::OFF_TRIGGER, cfg);
      wr(dts_pkg::OFF_CONTROL, 8'hc0);
      @(posedge core_clk);
      cmp_a_match <= ev[0];
      cmp_b_match <= ev[1];
      cmp_a_exec  <= ev[0] & ev[2];
      cmp_b_exec  <= ev[1] & ev[2];
      addr_valid  <= ev[3];
      addr_ge_a   <= ev[3] & ~ev[4];
      addr_le_b   <= ev[3];
      hit = 1'b0;
      repeat (4) begin
         @(posedge core_clk);
         {cmp_a_match, cmp_b_match, cmp_a_exec, cmp_b_exec, addr_valid} <= '0;
         hit |= trigger_q;
      end
      chk({7'h0, hit}, {7'h0, e});
      wr(dts_pkg::OFF_CONTROL, 8'h00);
      chk({7'h0, capture_enable_q}, 8'h00);
   endtask
   ////////////////////////////////////////
   task automatic t_regs;
      logic [7:0] d;
      for (int i = 0; i < 5; i++) rc(8'(4 * i), 8'h00);
      wr(dts_pkg::OFF_TRIGGER, 8'hff);
      rc(dts_pkg::OFF_TRIGGER, 8'hcf);
      wr(dts_pkg::OFF_TRIGGER, 8'h03);
      @(posedge core_clk);
      chk({5'h0, event_only_q, begin_trace_q, high_byte_zero_q}, 8'h07);
      wr(dts_pkg::OFF_STATUS, 8'hff);
      rc(dts_pkg::OFF_STATUS, 8'h00);
      rd(8'h14, d);
      chk({6'h0, lresp}, {6'h0, dts_pkg::RESP_SLVERR});
      secure_state <= 1'b1;
      wr(dts_pkg::OFF_CONTROL, 8'hc0);
      rd(dts_pkg::OFF_CONTROL, d);
      chk({d[7], 7'h0}, 8'h00);
      rc(dts_pkg::OFF_STATUS, 8'h00);
      secure_state <= 1'b0;
      wr(dts_pkg::OFF_CONTROL, 8'h00);
   endtask
   task automatic t_fill;
      int n;
      wr(dts_pkg::OFF_TRIGGER, 8'h40);
      wr(dts_pkg::OFF_CONTROL, 8'hc0);
      rc(dts_pkg::OFF_STATUS, 8'h20);
      wr(dts_pkg::OFF_TRIGGER, 8'h00);
      rc(dts_pkg::OFF_TRIGGER, 8'h40);
      fill <= 1'b1;
      n = 0;
      while (capture_enable_q && n < 200) begin
         @(posedge core_clk);
         n++;
      end
      fill <= 1'b0;
      rc(dts_pkg::OFF_STATUS, 8'h08);
      rc(dts_pkg::OFF_STATUS, 8'h08);
      irqc(dts_pkg::OFF_IRQ_MSK, 8'h00, 1'b0);
      irqc(dts_pkg::OFF_IRQ_MSK, 8'h01, 1'b1);
      irqc(dts_pkg::OFF_IRQ_STS, 8'h07, 1'b0);
      rc(dts_pkg::OFF_IRQ_STS, 8'h00);
   endtask
   task automatic t_modes;
      logic [15:0] expect_hit;
      expect_hit = 16'h00ab;
      for (int m = 0; m < 16; m++) begin
         run(8'(m), 5'b01011, expect_hit[m]);
      end
      run(8'h08, 5'b11000, 1'b1);
      run(8'h07, 5'b11000, 1'b0);
      run(8'h80, 5'b00001, 1'b0);
      run(8'h80, 5'b00101, 1'b1);
      run(8'h01, 5'b00011, 1'b1);
      rc(dts_pkg::OFF_STATUS, 8'hc0);
      run(8'h06, 5'b00000, 1'b0);
      rc(dts_pkg::OFF_STATUS, 8'h00);
   endtask
   task automatic t_seq;
      wr(dts_pkg::OFF_TRIGGER, 8'h02);
      wr(dts_pkg::OFF_CONTROL, 8'hc0);
      @(posedge core_clk);
      cmp_a_match <= 1'b1;
      @(posedge core_clk);
      cmp_a_match <= 1'b0;
      cmp_b_match <= 1'b1;
      @(posedge core_clk);
      cmp_b_match <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk({7'h0, capture_enable_q}, 8'h00);
      rc(dts_pkg::OFF_STATUS, 8'hc0);
   endtask
   task automatic conclude;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      #400000;
      n_fail++;
      conclude();
   end
   initial begin
      n_fail = 0;
      checked = 0;
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'h1;
      {secure_state, fill, cmp_a_match, cmp_b_match, cmp_a_exec, cmp_b_exec} = '0;
      {addr_ge_a, addr_le_b, addr_valid} = '0;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      t_regs();
      t_fill();
      t_modes();
      t_seq();
      conclude();
   end
endmodule // dts_top_tb
